// ### core/sqwd_dev.sv
`timescale 1ns/10ps
`include "sqwd_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - sequencer counts with no CPU involvement
// - falling edge on trigger raises request
// - CPU makes trigger by low pulse
// - CPU drives trigger levels as output
// - trigger request starts one sequencer run
// - each run increments then checks overflow
// - overflow raises end interrupt to CPU
// - counting continues after clears stop
// - CPU clears counter before overflow
// - CPU stops clearing on switch press
// - CPU lights LED on end interrupt
// - clear writes zero, limit 0x00FA
module sqwd_dev #(
    parameter logic [`SQWD_CNT_W-1:0] LIMIT = `SQWD_COUNTER_LIMIT
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    sqwd_link_if.dev link, // link to cpu end
    output logic busy // sequencer run active
);
    sqwd_pkg::sqwd_seq_state_t st_q;
    sqwd_pkg::sqwd_seq_state_t st_d;
    logic [`SQWD_CNT_W-1:0] cnt_q;
    logic [`SQWD_CNT_W-1:0] cnt_d;
    logic irq_q;
    logic irq_d;
    logic busy_q;
    logic busy_d;
    logic clr_q;
    logic clr_d;
    logic start;
    logic inc_en;
    logic eval_en;
    logic at_limit;

    ////////////////////////////////////////////////////////////////////////
    // trigger line, sampled as a pin and reduced to a one-cycle pulse
    sqwd_edge_det i_sqwd_edge_det (
        .clk(clk),
        .srst(srst),
        .pin(link.trigger_out_port),
        .fall(start)
    );

    ////////////////////////////////////////////////////////////////////////
    // run sequencer: one increment step, then one evaluate step
    // edges that land mid-run are dropped, never queued
    // start pulse -> increment -> evaluate -> idle, two cycles a run
    always_comb begin
        st_d = st_q;
        inc_en = 1'b0;
        eval_en = 1'b0;
        case (st_q)
            sqwd_pkg::SQWD_IDLE: begin
                inc_en = 1'b0;
                eval_en = 1'b0;
                if (start) begin
                    st_d = sqwd_pkg::SQWD_INCR;
                end else begin
                    st_d = sqwd_pkg::SQWD_IDLE;
                end
            end
            sqwd_pkg::SQWD_INCR: begin
                inc_en = 1'b1;
                eval_en = 1'b0;
                st_d = sqwd_pkg::SQWD_EVAL;
            end
            sqwd_pkg::SQWD_EVAL: begin
                inc_en = 1'b0;
                eval_en = 1'b1;
                st_d = sqwd_pkg::SQWD_IDLE;
            end
            default: begin
                inc_en = 1'b0;
                eval_en = 1'b0;
                st_d = sqwd_pkg::SQWD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= sqwd_pkg::SQWD_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear strobe from the cpu end, held one cycle so it meets the
    // counter step on a clean edge
    always_comb begin
        clr_d = link.counter_clear;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= clr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog counter: only the clear strobe touches it from outside
    // clear beats a step in the same cycle, so a clear is never lost
    // no saturation: it wraps at full width, far beyond the limit
    always_comb begin
        cnt_d = cnt_q;
        if (clr_q) begin
            cnt_d = `SQWD_COUNTER_CLEAR;
        end else if (inc_en) begin
            cnt_d = cnt_q + `SQWD_CNT_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= `SQWD_COUNTER_CLEAR;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow compare, at or above, so a step past the limit still flags
    // the request repeats on every run until the counter is cleared
    always_comb begin
        at_limit = (cnt_q >= LIMIT);
        irq_d = 1'b0;
        if (eval_en) begin
            irq_d = at_limit;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run-active flag, high through the increment and evaluate steps
    always_comb begin
        busy_d = (st_d != sqwd_pkg::SQWD_IDLE);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // every output straight from a register
    assign link.sequencer_end_irq = irq_q;
    assign link.counter = cnt_q;
    assign busy = busy_q;
endmodule // sqwd_dev

// ### core/sqwd_cfg.svh
`ifndef SQWD_CFG_SVH
`define SQWD_CFG_SVH

// clock and timing
`define SQWD_CLK_HZ 25000000
`define SQWD_RETRIG_US 4000
`define SQWD_RETRIG_CYC ((`SQWD_CLK_HZ / 1000000) * `SQWD_RETRIG_US)
`define SQWD_PULSE_CYC 4
`define SQWD_CLEAR_US 100000
`define SQWD_CLEAR_CYC ((`SQWD_CLK_HZ / 1000000) * `SQWD_CLEAR_US)

// counter values
`define SQWD_CNT_W 16
`define SQWD_COUNTER_CLEAR 16'h0000
`define SQWD_COUNTER_LIMIT 16'h00FA

`endif

// ### core/sqwd_pkg.sv
package sqwd_pkg;

    typedef enum logic [1:0] {
        SQWD_IDLE = 2'b00,
        SQWD_INCR = 2'b01,
        SQWD_EVAL = 2'b11
    } sqwd_seq_state_t;

    typedef enum logic [1:0] {
        SQWD_H_WAIT = 2'b00,
        SQWD_H_LOW = 2'b01,
        SQWD_H_HIGH = 2'b11
    } sqwd_host_state_t;

endpackage

// ### core/sqwd_link_if.sv
`timescale 1ns/10ps
`include "sqwd_cfg.svh"

interface sqwd_link_if;
    logic trigger_out_port;
    logic counter_clear;
    logic sequencer_end_irq;
    logic [`SQWD_CNT_W-1:0] counter;

    modport host (
        output trigger_out_port,
        output counter_clear,
        input sequencer_end_irq,
        input counter
    );
    modport dev (
        input trigger_out_port,
        input counter_clear,
        output sequencer_end_irq,
        output counter
    );
endinterface

// ### core/sqwd_edge_det.sv
`timescale 1ns/10ps

module sqwd_edge_det (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic pin, // async pin
    output logic fall // one-cycle falling edge
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic fall_q;
    logic fall_d;

    always_comb begin
        sync_d = {sync_q[1:0], pin};
        fall_d = sync_q[2] & ~sync_q[1];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_q <= 3'h7;
            fall_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            fall_q <= fall_d;
        end
    end

    assign fall = fall_q;
endmodule // sqwd_edge_det

// ### core/sqwd_host.sv
`timescale 1ns/10ps
`include "sqwd_cfg.svh"

module sqwd_host #(
    parameter int RETRIG_CYC = `SQWD_RETRIG_CYC,
    parameter int CLEAR_CYC = `SQWD_CLEAR_CYC,
    parameter int PULSE_CYC = `SQWD_PULSE_CYC
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    sqwd_link_if.host link, // link to sequencer
    input wire logic switch_in_port, // switch, high = pressed
    output logic led_out_port // led, high = lit
);
    sqwd_pkg::sqwd_host_state_t st_q;
    sqwd_pkg::sqwd_host_state_t st_d;
    logic [31:0] tmr_q;
    logic [31:0] tmr_d;
    logic [31:0] clr_tmr_q;
    logic [31:0] clr_tmr_d;
    logic trig_q;
    logic trig_d;
    logic clr_q;
    logic clr_d;
    logic stop_q;
    logic stop_d;
    logic led_q;
    logic led_d;
    logic [1:0] sw_sync_q;
    logic [1:0] sw_sync_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + 32'h1;
        trig_d = 1'b1;
        case (st_q)
            sqwd_pkg::SQWD_H_WAIT: begin
                if (tmr_q >= 32'(RETRIG_CYC - 1)) begin
                    st_d = sqwd_pkg::SQWD_H_LOW;
                    tmr_d = 32'h0;
                    trig_d = 1'b0;
                end
            end
            sqwd_pkg::SQWD_H_LOW: begin
                trig_d = 1'b0;
                if (tmr_q >= 32'(PULSE_CYC - 1)) begin
                    st_d = sqwd_pkg::SQWD_H_HIGH;
                    trig_d = 1'b1;
                end
            end
            sqwd_pkg::SQWD_H_HIGH: begin
                // timer keeps running, so the period is RETRIG_CYC exactly
                st_d = sqwd_pkg::SQWD_H_WAIT;
            end
            default: begin
                st_d = sqwd_pkg::SQWD_H_WAIT;
                tmr_d = 32'h0;
            end
        endcase
        sw_sync_d = {sw_sync_q[0], switch_in_port};
        stop_d = stop_q | sw_sync_q[1];
        clr_tmr_d = clr_tmr_q + 32'h1;
        clr_d = 1'b0;
        if (clr_tmr_q >= 32'(CLEAR_CYC - 1)) begin
            clr_tmr_d = 32'h0;
            clr_d = ~stop_d;
        end
        led_d = led_q | link.sequencer_end_irq;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= sqwd_pkg::SQWD_H_WAIT;
            tmr_q <= 32'h0;
            clr_tmr_q <= 32'h0;
            trig_q <= 1'b1;
            clr_q <= 1'b0;
            stop_q <= 1'b0;
            led_q <= 1'b0;
            sw_sync_q <= 2'h0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            clr_tmr_q <= clr_tmr_d;
            trig_q <= trig_d;
            clr_q <= clr_d;
            stop_q <= stop_d;
            led_q <= led_d;
            sw_sync_q <= sw_sync_d;
        end
    end

    assign link.trigger_out_port = trig_q;
    assign link.counter_clear = clr_q;
    assign led_out_port = led_q;
endmodule // sqwd_host

// ### verification/sqwd_link_asserts.sv
`timescale 1ns/10ps
module sqwd_link_asserts (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic trigger_out_port, // trigger line
    input wire logic counter_clear, // clear pulse
    input wire logic sequencer_end_irq, // end interrupt
    input wire logic [15:0] counter // watchdog count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_irq_one_cycle:
    assert property (sequencer_end_irq |=> !sequencer_end_irq)
        else $error("end irq held too long");
    chk_irq_at_limit:
    assert property (sequencer_end_irq |-> counter >= 16'h00FA)
        else $error("end irq below limit");
    chk_irq_after_inc:
    assert property (sequencer_end_irq |-> $past(counter) != $past(counter, 2))
        else $error("end irq without increment");
    chk_count_step:
    assert property (counter != $past(counter) |->
        (counter == $past(counter) + 16'h0001 || counter == 16'h0000))
        else $error("counter jumped");
    chk_clear_zero:
    assert property (counter_clear |-> ##2 counter == 16'h0000)
        else $error("clear not applied");
    chk_run_counts:
    assert property ($fell(trigger_out_port) |-> ##[3:6] counter != $past(counter))
        else $error("run did not count");
    chk_trig_low_pulse:
    assert property ($fell(trigger_out_port) |-> ##[1:8] trigger_out_port)
        else $error("trigger pulse too long");
    chk_trig_spacing:
    assert property ($fell(trigger_out_port) |=> !$fell(trigger_out_port) [*3])
        else $error("trigger edges too close");
    chk_clear_pulse:
    assert property (counter_clear |=> !counter_clear)
        else $error("clear held too long");
endmodule // sqwd_link_asserts

// ### verification/tb_sequencer_watchdog_counter.sv
`timescale 1ns/10ps
module tb_sequencer_watchdog_counter;
    localparam int RT = 20;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic press = 1'b0;
    logic led;
    logic busy;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    sqwd_link_if link ();
    sqwd_dev i_sqwd_dev (.clk(clk), .srst(srst), .link(link), .busy(busy));
    sqwd_host #(.RETRIG_CYC(RT), .CLEAR_CYC(200), .PULSE_CYC(2)) i_sqwd_host (
        .clk(clk), .srst(srst), .link(link), .switch_in_port(press),
        .led_out_port(led));
    sqwd_link_asserts i_sqwd_link_asserts (.clk(clk), .srst(srst),
        .trigger_out_port(link.trigger_out_port),
        .counter_clear(link.counter_clear),
        .sequencer_end_irq(link.sequencer_end_irq), .counter(link.counter));
    always #20 clk = ~clk;
    // cycle count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_normal();
        int clears;
        int n_busy;
        int n_inc;
        logic hit;
        logic [15:0] prev;
        clears = 0;
        n_busy = 0;
        n_inc = 0;
        hit = 1'b0;
        prev = link.counter;
        repeat (1000) begin
            @(negedge clk);
            if (link.counter_clear === 1'b1) clears++;
            if (link.sequencer_end_irq !== 1'b0) hit = 1'b1;
            if (busy === 1'b1) n_busy++;
            if (link.counter === prev + 16'h0001) n_inc++;
            prev = link.counter;
        end
        check(16'(clears), 16'h0005);
        check(16'(n_inc), 16'h0031);
        check(16'(n_busy), 16'h0062);
        check({15'h0, hit}, 16'h0000);
        check({15'h0, led}, 16'h0000);
    endtask
    task automatic t_overflow();
        int t0;
        int t_clr;
        int t_irq;
        int n_irq;
        @(posedge clk) press <= 1'b1;
        t0 = cyc;
        t_clr = cyc;
        t_irq = 0;
        n_irq = 0;
        while (t_irq == 0) begin
            @(negedge clk);
            if (link.counter_clear === 1'b1) t_clr = cyc;
            if (link.sequencer_end_irq === 1'b1) t_irq = cyc;
        end
        check(link.counter, 16'h00FA);
        check({15'h0, 1'(t_clr - t0 < 6)}, 16'h0001);
        check({15'h0, 1'(t_irq - t_clr > 249 * RT)}, 16'h0001);
        check({15'h0, 1'(t_irq - t_clr < 251 * RT)}, 16'h0001);
        @(negedge clk);
        check({15'h0, led}, 16'h0001);
        repeat (RT * 7 / 2 - 1) begin
            @(negedge clk);
            if (link.sequencer_end_irq === 1'b1) n_irq++;
        end
        check(16'(n_irq), 16'h0003);
        check({15'h0, led}, 16'h0001);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check(link.counter, 16'h0000);
        check({15'h0, busy}, 16'h0000);
        t_normal();
        t_overflow();
        @(posedge clk) srst <= 1'b1;
        press <= 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check(link.counter, 16'h0000);
        t_normal();
        results();
    end
endmodule // tb_sequencer_watchdog_counter
